// file: dasp_pkg.sv
`default_nettype none

package dasp_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] FMT_CTRL_OFS = 8'h70;
   localparam logic [7:0] ROLE_CTRL_OFS = 8'h74;
   localparam logic [7:0] STATUS_OFS = 8'h78;
   localparam logic [15:0] FMT_CTRL_RST = 16'h0a00;
   localparam logic [2:0] ROLE_CTRL_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BCLK_INV_BIT = 15;
   localparam int TRI_BIT = 13;
   localparam int LRCLK_INV_BIT = 12;
   localparam int WL_LSB = 10;
   localparam int FMT_LSB = 8;
   localparam int DAC_MASTER_BIT = 0;
   localparam int ADC_MASTER_BIT = 1;
   localparam int ADC_SEP_BIT = 2;
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_HALF_LSB = 16;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {
      FMT_RJ = 2'h0,
      FMT_LJ = 2'h1,
      FMT_I2S = 2'h2,
      FMT_DSP = 2'h3
   } dasp_fmt_t;

   localparam logic [1:0] WL_16 = 2'h0;
   localparam logic [1:0] WL_20 = 2'h1;
   localparam logic [1:0] WL_24 = 2'h2;
   localparam logic [5:0] LEN_16 = 6'h10;
   localparam logic [5:0] LEN_20 = 6'h14;
   localparam logic [5:0] LEN_24 = 6'h18;
   localparam logic [5:0] LEN_32 = 6'h20;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int BCLK_HALF_NS = 40;
   localparam int BCLK_HALF_CYC =
      (BCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);
   localparam int FRAME_CNT_W = 6;
   localparam logic [6:0] CNT_MAX = 7'h7f;

endpackage : dasp_pkg

`default_nettype wire

// file: dasp_clk_gen.sv
`default_nettype none

module dasp_clk_gen
   import dasp_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic dspMode,
   output logic bitClk,
   output logic wordClk
);

   logic [DIV_W-1:0] divCnt;
   logic [FRAME_CNT_W-1:0] bitCnt;
   logic [FRAME_CNT_W-1:0] next_bitCnt;

   assign next_bitCnt = bitCnt + 1'b1;

   // Word clock moves only on the falling bit clock edge, so the far end
   // always samples it stable on the rising edge.
   always_ff @(posedge core_clk) begin
      if (!nrst || !enable) begin
         divCnt <= '0;
         bitClk <= 1'b0;
         bitCnt <= '0;
         wordClk <= 1'b0;
      end else if (divCnt == DIV_LAST) begin
         divCnt <= '0;
         bitClk <= !bitClk;
         if (bitClk) begin
            bitCnt <= next_bitCnt;
            if (dspMode) begin
               wordClk <= (next_bitCnt == '0);
            end else begin
               wordClk <= next_bitCnt[FRAME_CNT_W-1];
            end
         end
      end else begin
         divCnt <= divCnt + 1'b1;
      end
   end

endmodule : dasp_clk_gen

`default_nettype wire

// file: dasp_serial_port.sv
// Function
// - Four dedicated pins: data out, in, clocks
// - Master drives clocks, slave receives them
// - Separate ADC word and bit clocks offered
// - ADC and DAC roles chosen independently when ADC clocks are separate
// - Left, right justified, I2S, DSP A/B framing
// - Every word shifts MSB first, LSB last
// - Float bit releases clocks and data out
// - DSP mode A: MSB on second edge
// - DSP mode B: MSB on first edge
// - Word length code picks 16/20/24/32 bits
// - Format code selects RJ, LJ, I2S, DSP
// - Left justified: MSB on first edge
// - Right justified: LSB before word transition
// - I2S: MSB on second edge after transition
`default_nettype none

module dasp_serial_port
   import dasp_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   // Register bus
   input wire logic [dasp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dasp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter side
   input wire logic [31:0] adcLeft,
   input wire logic [31:0] adcRight,
   output logic [31:0] dacLeft,
   output logic [31:0] dacRight,
   output logic dacStrobe,
   // Serial port pins
   output logic adcSerialOut,
   output logic adcSerialOutOe,
   input wire logic dacSerialIn,
   input wire logic wordClockIn,
   output logic wordClockOut,
   output logic wordClockOe,
   input wire logic bitClockIn,
   output logic bitClockOut,
   output logic bitClockOe,
   input wire logic adcWordSelectClockIn,
   output logic adcWordSelectClockOut,
   output logic adcWordSelectClockOe,
   input wire logic adcSerialBitClockIn,
   output logic adcSerialBitClockOut,
   output logic adcSerialBitClockOe
);

   // ****************************************
   // Registers and decoded controls
   // ****************************************
   logic [15:0] serialPortFormatControl;
   logic [2:0] roleControl;
   logic [15:0] frameCount;
   logic bitClockPolaritySelect;
   logic portPinsFloatForce;
   logic wordClockPolaritySelect;
   logic [1:0] sampleWordLength;
   dasp_fmt_t framingFormatSelect;
   logic dspMode;
   logic [5:0] wordBits;
   logic wsInvert;
   logic leftLevel;

   assign bitClockPolaritySelect = serialPortFormatControl[BCLK_INV_BIT];
   assign portPinsFloatForce = serialPortFormatControl[TRI_BIT];
   assign wordClockPolaritySelect = serialPortFormatControl[LRCLK_INV_BIT];
   assign sampleWordLength = serialPortFormatControl[WL_LSB +: 2];
   assign framingFormatSelect =
      dasp_fmt_t'(serialPortFormatControl[FMT_LSB +: 2]);
   assign dspMode = (framingFormatSelect == FMT_DSP);
   // In DSP framing the polarity bit picks mode A or B instead
   assign wsInvert = wordClockPolaritySelect && !dspMode;
   // I2S carries the left word while the word clock is low
   assign leftLevel = (framingFormatSelect != FMT_I2S);

   always_comb begin
      case (sampleWordLength)
         WL_16: wordBits = LEN_16;
         WL_20: wordBits = LEN_20;
         WL_24: wordBits = LEN_24;
         default: wordBits = LEN_32;
      endcase
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0] pinMeta;
   logic [4:0] pinSync;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pinMeta <= '0;
         pinSync <= '0;
      end else begin
         pinMeta <= {dacSerialIn, adcWordSelectClockIn, adcSerialBitClockIn,
                     wordClockIn, bitClockIn};
         pinSync <= pinMeta;
      end
   end

   // ****************************************
   // Master clock generators
   // ****************************************
   logic [1:0] pathMaster;
   logic [1:0] genBit;
   logic [1:0] genWord;

   assign pathMaster[0] = roleControl[DAC_MASTER_BIT];
   assign pathMaster[1] = roleControl[ADC_MASTER_BIT]
      && roleControl[ADC_SEP_BIT];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : genClk
         dasp_clk_gen uGen (
            .core_clk(core_clk),
            .nrst(nrst),
            .enable(pathMaster[g]),
            .dspMode(dspMode),
            .bitClk(genBit[g]),
            .wordClk(genWord[g])
         );
      end
   endgenerate

   // ****************************************
   // Timing source per path
   // ****************************************
   // Path 0 serves the DAC input, path 1 the ADC output. Sources carry
   // the effective polarity: pins are corrected on the way in and out.
   logic [1:0] effBit;
   logic [1:0] effWord;

   always_comb begin
      effBit[0] = pathMaster[0] ? genBit[0]
         : pinSync[0] ^ bitClockPolaritySelect;
      effWord[0] = pathMaster[0] ? genWord[0] : pinSync[1] ^ wsInvert;
      if (!roleControl[ADC_SEP_BIT]) begin
         effBit[1] = effBit[0];
         effWord[1] = effWord[0];
      end else if (pathMaster[1]) begin
         effBit[1] = genBit[1];
         effWord[1] = genWord[1];
      end else begin
         effBit[1] = pinSync[2] ^ bitClockPolaritySelect;
         effWord[1] = pinSync[3] ^ wsInvert;
      end
   end

   // ****************************************
   // Bit position tracking
   // ****************************************
   function automatic logic [7:0] posOf(
      input logic [6:0] idx,
      input logic [6:0] half,
      input dasp_fmt_t fmt,
      input logic [5:0] len,
      input logic modeB
   );
      logic [7:0] pos;
      pos = {1'b0, idx};
      case (fmt)
         FMT_RJ: pos = {1'b0, idx} - ({1'b0, half} - {2'b0, len});
         FMT_LJ: pos = {1'b0, idx};
         FMT_I2S: pos = {1'b0, idx} - 8'h01;
         default: pos = modeB ? {1'b0, idx}
            : {1'b0, idx} - 8'h01;
      endcase
      return pos;
   endfunction : posOf

   logic bitPrev [2];
   logic wordAtRise [2];
   logic [6:0] edgeCnt [2];
   logic [6:0] halfLen [2];
   logic [1:0] riseEv;
   logic [1:0] fallEv;
   logic [1:0] newHalf;
   logic [6:0] idxNow [2];
   logic [7:0] posNow [2];
   logic [7:0] posLimit;

   assign posLimit = dspMode ? {1'b0, wordBits, 1'b0} : {2'b0, wordBits};

   generate
      for (g = 0; g < 2; g++) begin : genTrack
         assign riseEv[g] = effBit[g] && !bitPrev[g];
         assign fallEv[g] = !effBit[g] && bitPrev[g];
         // A rising edge that sees a new word clock level opens a half;
         // in DSP framing only the rising word clock opens a frame.
         assign newHalf[g] = dspMode ? (effWord[g] && !wordAtRise[g])
            : (effWord[g] != wordAtRise[g]);
         assign idxNow[g] = newHalf[g] ? 7'h00
            : (edgeCnt[g] == CNT_MAX) ? CNT_MAX : edgeCnt[g] + 7'h01;
         assign posNow[g] = posOf(idxNow[g], halfLen[g],
            framingFormatSelect, wordBits, wordClockPolaritySelect);

         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               bitPrev[g] <= 1'b0;
               wordAtRise[g] <= 1'b0;
               edgeCnt[g] <= CNT_MAX;
               halfLen[g] <= '0;
            end else begin
               bitPrev[g] <= effBit[g];
               if (riseEv[g]) begin
                  wordAtRise[g] <= effWord[g];
                  edgeCnt[g] <= idxNow[g];
                  // Right justified placement needs the half length,
                  // so it settles only after one full half was seen.
                  if (newHalf[g] && !dspMode) begin
                     halfLen[g] <= edgeCnt[g] + 7'h01;
                  end
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // DAC receive
   // ****************************************
   logic [31:0] rxShift;
   logic rxInRange;
   logic [31:0] rxNext;

   assign rxInRange = posNow[0] < posLimit;
   assign rxNext = {rxShift[30:0], pinSync[4]};

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rxShift <= '0;
         dacLeft <= '0;
         dacRight <= '0;
         dacStrobe <= 1'b0;
      end else begin
         dacStrobe <= 1'b0;
         if (riseEv[0]) begin
            if (newHalf[0]) begin
               if (dspMode || wordAtRise[0] != leftLevel) begin
                  dacRight <= rxShift;
                  dacStrobe <= 1'b1;
               end else begin
                  dacLeft <= rxShift;
               end
               rxShift <= rxInRange ? {31'h0, pinSync[4]} : '0;
            end else if (rxInRange) begin
               if (dspMode && posNow[0] == {2'b0, wordBits} - 8'h01) begin
                  dacLeft <= rxNext;
                  rxShift <= '0;
               end else begin
                  rxShift <= rxNext;
               end
            end
         end
      end
   end

   // ****************************************
   // ADC transmit
   // ****************************************
   // Data is launched on the falling edge ahead of the rising edge that
   // samples it, using the word clock level already present then.
   logic [31:0] txLeft;
   logic [31:0] txRight;
   logic txChanRight;
   logic [7:0] txPos;
   logic [7:0] txBitSel;
   logic [31:0] txWord;
   logic txInRange;

   always_comb begin
      if (dspMode) begin
         txChanRight = posNow[1] >= {2'b0, wordBits};
      end else begin
         txChanRight = effWord[1] != leftLevel;
      end
      txPos = (dspMode && txChanRight)
         ? posNow[1] - {2'b0, wordBits} : posNow[1];
      txBitSel = {2'b0, wordBits} - 8'h01 - txPos;
      if (txChanRight) begin
         txWord = newHalf[1] ? adcRight : txRight;
      end else begin
         txWord = newHalf[1] ? adcLeft : txLeft;
      end
      txInRange = posNow[1] < posLimit;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         txLeft <= '0;
         txRight <= '0;
         adcSerialOut <= 1'b0;
      end else if (fallEv[1]) begin
         if (newHalf[1]) begin
            txLeft <= adcLeft;
            txRight <= adcRight;
         end
         adcSerialOut <= txInRange && txWord[txBitSel[4:0]];
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bitClockOut <= 1'b0;
         wordClockOut <= 1'b0;
         adcSerialBitClockOut <= 1'b0;
         adcWordSelectClockOut <= 1'b0;
         bitClockOe <= 1'b0;
         wordClockOe <= 1'b0;
         adcSerialBitClockOe <= 1'b0;
         adcWordSelectClockOe <= 1'b0;
         adcSerialOutOe <= 1'b0;
      end else begin
         bitClockOut <= genBit[0] ^ bitClockPolaritySelect;
         wordClockOut <= genWord[0] ^ wsInvert;
         adcSerialBitClockOut <= genBit[1] ^ bitClockPolaritySelect;
         adcWordSelectClockOut <= genWord[1] ^ wsInvert;
         bitClockOe <= pathMaster[0] && !portPinsFloatForce;
         wordClockOe <= pathMaster[0] && !portPinsFloatForce;
         adcSerialBitClockOe <= pathMaster[1] && !portPinsFloatForce;
         adcWordSelectClockOe <= pathMaster[1] && !portPinsFloatForce;
         adcSerialOutOe <= !portPinsFloatForce;
      end
   end

   // ****************************************
   // Register bus slave
   // ****************************************
   logic [ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic awHeld;
   logic wHeld;
   logic [31:0] rdValue;
   logic rdHit;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         wrAddr <= '0;
         wrData <= '0;
         wrStrb <= '0;
         serialPortFormatControl <= FMT_CTRL_RST;
         roleControl <= ROLE_CTRL_RST;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            wrAddr <= s_axi_awaddr;
            awHeld <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
            wHeld <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awHeld && wHeld && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (wrAddr[7:2] == FMT_CTRL_OFS[7:2]) begin
               if (wrStrb[0]) begin
                  serialPortFormatControl[7:0] <= wrData[7:0];
               end
               if (wrStrb[1]) begin
                  serialPortFormatControl[15:8] <= wrData[15:8];
               end
            end else if (wrAddr[7:2] == ROLE_CTRL_OFS[7:2]) begin
               if (wrStrb[0]) begin
                  roleControl <= wrData[2:0];
               end
            end else if (wrAddr[7:2] != STATUS_OFS[7:2]) begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end

   always_comb begin
      rdHit = 1'b1;
      rdValue = '0;
      case (s_axi_araddr[7:2])
         FMT_CTRL_OFS[7:2]: rdValue[15:0] = serialPortFormatControl;
         ROLE_CTRL_OFS[7:2]: rdValue[2:0] = roleControl;
         STATUS_OFS[7:2]: begin
            rdValue[STAT_CNT_LSB +: 16] = frameCount;
            rdValue[STAT_HALF_LSB +: 7] = halfLen[0];
         end
         default: rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         frameCount <= '0;
      end else if (riseEv[0] && newHalf[0]
                   && (dspMode || wordAtRise[0] != leftLevel)) begin
         frameCount <= frameCount + 16'h0001;
      end
   end

endmodule : dasp_serial_port

`default_nettype wire

// file: dasp_serial_port_sva.sv
`default_nettype none
module dasp_serial_port_sva (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] dacRight,
   input wire logic dacStrobe,
   input wire logic adcSerialOutOe,
   input wire logic bitClockOut,
   input wire logic bitClockOe,
   input wire logic wordClockOe,
   input wire logic adcSerialBitClockOe,
   input wire logic adcWordSelectClockOe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // ****************************************
   // Register bus
   // ****************************************
   wr_answer_a:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##[2:3] s_axi_bvalid)
      else $error("no write response");
   aw_block_a:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready in response");
   rd_answer_a:
      assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("no read data");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready in data");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid repeated");
   // ****************************************
   // Pins
   // ****************************************
   clk_pair_a: assert property (bitClockOe == wordClockOe)
      else $error("enables differ");
   adc_pair_a:
      assert property (adcSerialBitClockOe == adcWordSelectClockOe)
      else $error("adc enables differ");
   float_all_a:
      assert property (bitClockOe || adcSerialBitClockOe |-> adcSerialOutOe)
      else $error("data floats");
   master_half_a:
      assert property (bitClockOe && $changed(bitClockOut) ##1 bitClockOe[*4]
         |-> $changed(bitClockOut))
      else $error("bad half period");
   strobe_pulse_a: assert property (dacStrobe |=> !dacStrobe)
      else $error("long strobe");
   dac_latch_a: assert property ($changed(dacRight) |-> dacStrobe)
      else $error("silent right word");
endmodule : dasp_serial_port_sva

bind dasp_serial_port dasp_serial_port_sva dasp_serial_port_sva_inst (
   .core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .dacRight, .dacStrobe, .adcSerialOutOe,
   .bitClockOut, .bitClockOe, .wordClockOe, .adcSerialBitClockOe,
   .adcWordSelectClockOe
);
`default_nettype wire

// file: dasp_host_model.sv
`default_nettype none
module dasp_host_model
   import dasp_pkg::*;
(
   input wire logic dataIn,
   output logic bitClk,
   output logic wordClk,
   output logic dataOut
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {bitClk, wordClk, dataOut} = 3'b100;
   // ****************************************
   // Three frames of 64 bit clocks
   // ****************************************
   // Clocks idle between calls; spare slots toggle data
   task automatic run(input logic [15:0] cfg, input logic [31:0] txL, txR,
      output logic [31:0] rxL, rxR);
      logic [1:0] fmt;
      logic dsp, rgt;
      int n, off, k;
      fmt = cfg[FMT_LSB+:2];
      dsp = fmt == FMT_DSP;
      n = cfg[WL_LSB+:2] == 2'h3 ? 32 : 16 + 4 * cfg[WL_LSB+:2];
      off = fmt == FMT_RJ ? 32 - n :
         (fmt == FMT_LJ || (dsp && cfg[LRCLK_INV_BIT])) ? 0 : 1;
      #3;
      repeat (3) for (int p = 0; p < 64; p++) begin
         k = dsp ? p - off : p % 32 - off;
         rgt = dsp ? k >= n : p >= 32;
         if (dsp && rgt) k -= n;
         if (p == 0) {rxL, rxR} = '0;
         wordClk = dsp ? p == 0 :
            (p >= 32) ^ (fmt != FMT_I2S) ^ cfg[LRCLK_INV_BIT];
         bitClk = cfg[BCLK_INV_BIT];
         dataOut = (k >= 0 && k < n) ?
            (rgt ? txR[n-1-k] : txL[n-1-k]) : ~dataOut;
         #62;
         bitClk = ~cfg[BCLK_INV_BIT];
         if (k >= 0 && k < n && rgt) rxR = {rxR[30:0], dataIn};
         else if (k >= 0 && k < n) rxL = {rxL[30:0], dataIn};
         #63;
      end
      dataOut = ~dataOut;
   endtask : run
endmodule : dasp_host_model
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
   import dasp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] TX_L = 32'h96e14b2d;
   localparam logic [31:0] TX_R = 32'h2d4be196;
   logic core_clk, nrst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, adcLeft, adcRight, dacLeft, dacRight;
   logic [31:0] rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, dacStrobe, adcSerialOut, adcSerialOutOe;
   logic wordClockOut, wordClockOe, bitClockOut, bitClockOe, hBit, hWord;
   logic adcWordSelectClockOut, adcWordSelectClockOe, hData;
   logic adcSerialBitClockOut, adcSerialBitClockOe;
   int badCount = 0, cmpCount = 0, cycles = 0;
   // LJ16, LJ16 inv, I2S24, RJ20, RJ24 (never RJ32), I2S20, DSP A24, B32
   logic [15:0] cases [0:7] = '{16'h0100, 16'h9100, 16'h0a00, 16'h0400,
      16'h0800, 16'h0600, 16'h0b00, 16'h1f00};
   // Pins resolve to their driver
   wire logic bitClockIn = bitClockOe ? bitClockOut : hBit;
   wire logic wordClockIn = wordClockOe ? wordClockOut : hWord;
   wire logic adcSerialBitClockIn = adcSerialBitClockOe ?
      adcSerialBitClockOut : hBit;
   wire logic adcWordSelectClockIn = adcWordSelectClockOe ?
      adcWordSelectClockOut : hWord;
   wire logic dacSerialIn = hData;
   wire logic adcPin = adcSerialOutOe ? adcSerialOut : 1'bz;

   dasp_serial_port dasp_serial_port_inst (
      .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .adcLeft, .adcRight, .dacLeft, .dacRight, .dacStrobe,
      .adcSerialOut, .adcSerialOutOe, .dacSerialIn, .wordClockIn,
      .wordClockOut, .wordClockOe, .bitClockIn, .bitClockOut, .bitClockOe,
      .adcWordSelectClockIn, .adcWordSelectClockOut, .adcWordSelectClockOe,
      .adcSerialBitClockIn, .adcSerialBitClockOut, .adcSerialBitClockOe
   );
   dasp_host_model dasp_host_model_inst (
      .dataIn(adcPin),
      .bitClk(hBit),
      .wordClk(hWord),
      .dataOut(hData)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         badCount++;
         endSim();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input logic [31:0] got, exp);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task axiWrite(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axiWrite
   task axiRead(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axiRead
   task runCase(input logic [15:0] cfg);
      logic [31:0] rl, rr, m;
      int n;
      n = cfg[WL_LSB+:2] == 2'h3 ? 32 : 16 + 4 * cfg[WL_LSB+:2];
      m = 32'hffffffff >> (32 - n);
      adcLeft <= {adcLeft[0], adcLeft[31:1]};
      adcRight <= {adcRight[0], adcRight[31:1]};
      axiWrite(FMT_CTRL_OFS, {16'h0, cfg}, rs);
      chk(rs, RESP_OKAY);
      dasp_host_model_inst.run(cfg, TX_L, TX_R, rl, rr);
      chk(rl, adcLeft & m);
      chk(rr, adcRight & m);
      chk(dacLeft, TX_L & m);
      chk(dacRight, TX_R & m);
      $display("test format %h done", cfg);
   endtask : runCase
   task endSim();
      $display("compares %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : endSim
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      adcLeft = 32'hc35a9e17;
      adcRight = 32'h5ac317e9;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      axiRead(FMT_CTRL_OFS, rd, rs);
      chk(rd, {16'h0, FMT_CTRL_RST});
      axiRead(ROLE_CTRL_OFS, rd, rs);
      chk(rd, 32'h0);
      axiRead(8'h7c, rd, rs);
      chk(rs, RESP_SLVERR);
      axiWrite(8'h40, 32'h0000ffff, rs);
      chk(rs, RESP_SLVERR);
      $display("test registers done");
      foreach (cases[i]) runCase(cases[i]);
      axiWrite(ROLE_CTRL_OFS, 32'h1, rs);
      #1;
      chk(bitClockOe, 1'b1);
      chk(adcSerialBitClockOe, 1'b0);
      repeat (40) @(posedge core_clk);
      axiWrite(FMT_CTRL_OFS, 32'h2a00, rs);
      #1;
      chk({bitClockOe, adcSerialOutOe}, 32'h0);
      axiWrite(FMT_CTRL_OFS, 32'h0a00, rs);
      axiWrite(ROLE_CTRL_OFS, 32'h6, rs);
      #1;
      chk({adcSerialBitClockOe, bitClockOe, adcSerialOutOe}, 32'h5);
      $display("test roles done");
      endSim();
   end
endmodule : tb
`default_nettype wire
